// [design/rtc_core.sv]
// host port, bcd counter chain and interrupt pins of the real-time clock
`timescale 1ns/10ps
//Contract
//- chip select low needed for access
//- read and write strobes active low
//- power fail ignores strobes, finishes access
//- five address lines, ignored after fail
//- interrupt on enabled timing or fail
//- interrupt pin open drain active low
//- multi output: fail interrupt or oscillator
//- multi output push-pull, open drain standby
//- data lines released on fail without write
//- lockout 30 to 63 us after fail
//- eight byte counters hundredths to years
//- bcd counters advance on common clock
//- day, date, month wrap to one
//- twelve hour wraps to one, flag toggles
//- half day flag is hours bit seven
//- other counters wrap to zero
//- status bit selects control page
//- read spans select and read low
//- write spans select and write low
//- rollover interrupt about 20 us later
//- run bit clear halts counting, carries
//- chain ticks one hundred per second
module rtc_core (
	input  wire logic                  mclk_i,          // system clock
	input  wire logic                  rstn_i,          // sync reset, active low
	input  wire logic                  cs_n_i,          // chip select
	input  wire logic                  rd_n_i,          // read strobe
	input  wire logic                  wr_n_i,          // write strobe
	input  wire logic [rtc_pkg::ADDR_W-1:0] location_select_lines_i, // byte select
	input  wire logic [rtc_pkg::DATA_W-1:0] host_data_lines_i,       // data in
	output logic      [rtc_pkg::DATA_W-1:0] host_data_lines_o,       // data out
	output logic                       host_data_lines_oe_o,         // data drive enable
	input  wire logic                  power_loss_in_n_i,            // power fail pin
	input  wire logic                  backup_supply_i,              // high in battery standby
	input  wire logic                  osc_i,                        // oscillator level
	output logic                       irq_out_n_o,                  // interrupt pin level
	output logic                       irq_out_n_oe_o,               // interrupt pin drive
	output logic                       multi_purpose_out_o,          // multi output level
	output logic                       multi_purpose_out_oe_o        // multi output drive
);
	import rtc_pkg::*;
	// last hour of the day in twelve hour mode: 11 with half day flag set
	localparam logic [7:0] HOUR_LAST_12H = 8'h91;

	// whole module state
	typedef struct packed {
		rtc_acc_t                acc;       // access state
		logic [4:0]              addr;      // latched location
		logic [NCNT-1:0][7:0]    cnt;       // counter bytes
		logic [7:0]              main_st;   // main status
		logic [7:0]              rtmode;    // real time mode
		logic [7:0]              outmode;   // output mode
		logic [7:0]              ictl0;     // periodic enables
		logic [7:0]              ictl1;     // power fail enable etc
		logic [7:0]              pflag;     // periodic flags
		logic                    batt;      // battery backed mode
		logic                    locked;    // host lockout
		logic [DLY_W-1:0]        lock_dly;  // lockout delay count
		logic [DLY_W-1:0]        roll_dly;  // rollover irq delay
		logic                    roll_pend; // rollover irq pending
		logic [19:0]             presc;     // tick prescaler
		logic [7:0]              dout;      // data out
		logic                    doe;       // data drive
		logic                    irq_n;     // interrupt level
		logic                    irq_oe;    // interrupt drive
		logic                    mpo;       // multi output level
		logic                    mpo_oe;    // multi output drive
	} rtc_state_t;

	rtc_state_t st_reg;  // registered state
	rtc_state_t st_next; // next state

	// memory port
	logic       ram_we;    // ram write
	logic [7:0] ram_rdata; // ram read data

	// combinational helpers
	logic       sel_rd;       // read qualified
	logic       sel_wr;       // write qualified
	logic       tick;         // 100 Hz tick
	logic [NCNT:0] carry;     // carry chain
	logic [7:0]           inc_val [NCNT]; // incremented value, one process per entry
	logic [7:0] rd_mux;       // register read value
	logic       h12;          // twelve hour mode
	logic       pf_irq;       // power fail interrupt
	logic       any_irq;      // any interrupt active

	rtc_ram u_ram (
		.mclk_i  (mclk_i),
		.we_i    (ram_we),
		.waddr_i (st_reg.addr),
		.wdata_i (host_data_lines_i),
		.raddr_i (location_select_lines_i),
		.rdata_o (ram_rdata)
	);

	// per counter bcd increment and wrap
	// eight counters chained
	generate
		for (genvar g = 0; g < NCNT; g++) begin : g_cnt
			always_comb begin
				logic [7:0] v;
				v = st_reg.cnt[g];
				if (v == CNT_MAX[g]) begin
					inc_val[g] = CNT_WRAP[g];
				end else if (v[3:0] == BCD_NINE) begin
					inc_val[g] = {v[7:4] + 4'h1, 4'h0};
				end else begin
					inc_val[g] = {v[7:4], v[3:0] + 4'h1};
				end
			end
		end
	endgenerate

	// next state
	always_comb begin
		st_next = st_reg;
		ram_we  = 1'b0;
		h12     = ~st_reg.rtmode[RTM_12H_BIT];
		sel_rd  = ~cs_n_i & ~rd_n_i;
		sel_wr  = ~cs_n_i & ~wr_n_i;
		tick    = (st_reg.presc == 20'(TICK_CYC - 1));
		if (tick || !st_reg.rtmode[RTM_RUN_BIT]) begin
			st_next.presc = '0;
		end else begin
			st_next.presc = st_reg.presc + 20'h1;
		end
		// run bit gates tick and carries
		carry[0] = tick & st_reg.rtmode[RTM_RUN_BIT];
		// twelve hour mode turns the day at 11 pm
		for (int i = 0; i < NCNT; i++) begin
			if (h12 && i == C_HOUR) begin
				carry[i+1] = carry[i] & (st_reg.cnt[i] == HOUR_LAST_12H);
			end else begin
				carry[i+1] = carry[i] & (st_reg.cnt[i] == CNT_MAX[i]);
			end
		end
		// day of week advances with day of month
		// all bytes updated on one edge
		for (int i = 0; i < NCNT; i++) begin
			if ((i == C_DOW) ? carry[C_DOM] : carry[i]) begin
				st_next.cnt[i] = inc_val[i];
			end
		end
		if (h12 && carry[C_HOUR]) begin
			if (st_reg.cnt[C_HOUR][6:0] == BCD_TWELVE[6:0]) begin
				st_next.cnt[C_HOUR][6:0] = BCD_ONE[6:0];
			end else if (st_reg.cnt[C_HOUR][6:0] == 7'h11) begin
				// half day flag in bit seven
				st_next.cnt[C_HOUR] = {~st_reg.cnt[C_HOUR][HOUR_PM_BIT], BCD_TWELVE[6:0]};
			end else begin
				st_next.cnt[C_HOUR][HOUR_PM_BIT] = st_reg.cnt[C_HOUR][HOUR_PM_BIT];
				st_next.cnt[C_HOUR][6:0] = inc_val[C_HOUR][6:0];
			end
			// zero wrap only in 24 hour mode
		end
		// periodic flag on every second rollover
		if (carry[C_SEC]) begin
			st_next.pflag[0] = 1'b1;
			st_next.main_st[MS_PERIOD_BIT] = 1'b1;
			if (st_reg.ictl0[0]) begin
				st_next.roll_pend = 1'b1;
				st_next.roll_dly  = ROLL_CNT;
			end
		end else if (st_reg.roll_pend) begin
			if (st_reg.roll_dly == '0) begin
				st_next.roll_pend = 1'b0;
			end else begin
				st_next.roll_dly = st_reg.roll_dly - DLY_W'(1);
			end
		end
		// lockout after delay in battery mode
		if (!power_loss_in_n_i && st_reg.batt) begin
			if (st_reg.lock_dly == LOCK_CNT) begin
				st_next.locked = 1'b1;
			end else begin
				st_next.lock_dly = st_reg.lock_dly + DLY_W'(1);
			end
		end else begin
			st_next.lock_dly = '0;
			st_next.locked   = 1'b0;
		end
		// power fail status follows the pin while the irq ctl 1 power fail enable is set
		st_next.main_st[MS_PLOSS_BIT] = ~power_loss_in_n_i & st_reg.ictl1[IC1_PF_EN_BIT];
		// read mux, page chosen by status bit
		// page select
		rd_mux = ram_rdata;
		if (st_reg.addr == OFS_MAIN_STATUS) begin
			rd_mux = st_reg.main_st;
		end else if (st_reg.addr >= OFS_CNT_FIRST && st_reg.addr <= OFS_YEAR) begin
			rd_mux = st_reg.cnt[st_reg.addr - OFS_CNT_FIRST];
		end else if (st_reg.addr == OFS_DOW) begin
			rd_mux = st_reg.cnt[C_DOW];
		end else if (st_reg.main_st[MS_PAGE_BIT]) begin
			case (st_reg.addr)
				OFS_PAGE1: rd_mux = st_reg.rtmode;
				OFS_PAGE2: rd_mux = st_reg.outmode;
				OFS_PAGE3: rd_mux = st_reg.ictl0;
				OFS_PAGE4: rd_mux = st_reg.ictl1;
				default:   rd_mux = ram_rdata;
			endcase
		end else if (st_reg.addr == OFS_PAGE3) begin
			rd_mux = st_reg.pflag;
		end
		// host access state machine
		case (st_reg.acc)
			ACC_IDLE: begin
				// address taken only when not locked
				if (!st_reg.locked) begin
					st_next.addr = location_select_lines_i;
					if (sel_rd) begin
						st_next.acc = ACC_READ;
					end else if (sel_wr) begin
						st_next.acc = ACC_WRITE;
					end
				end
				st_next.doe = 1'b0;
			end
			ACC_READ: begin
				st_next.dout = rd_mux;
				st_next.doe  = sel_rd;
				// release data on fail during read
				if (!power_loss_in_n_i) begin
					st_next.doe = 1'b0;
				end
				if (!sel_rd) begin
					st_next.acc = ACC_IDLE;
				end
				// reading periodic flags clears them
				if (!sel_rd && st_reg.addr == OFS_PAGE3 && !st_reg.main_st[MS_PAGE_BIT]
					&& !carry[C_SEC]) begin
					st_next.pflag[0] = 1'b0;
				end
			end
			ACC_WRITE: begin
				st_next.doe = 1'b0;
				if (!sel_wr) begin
					st_next.acc = ACC_IDLE;
					if (st_reg.addr == OFS_MAIN_STATUS) begin
						st_next.main_st[MS_PAGE_BIT] = host_data_lines_i[MS_PAGE_BIT];
						// write one clears periodic status unless set now
						if (host_data_lines_i[MS_PERIOD_BIT] && !carry[C_SEC]) begin
							st_next.main_st[MS_PERIOD_BIT] = 1'b0;
						end
					end else if (st_reg.addr >= OFS_CNT_FIRST && st_reg.addr <= OFS_YEAR) begin
						st_next.cnt[st_reg.addr - OFS_CNT_FIRST] = host_data_lines_i;
					end else if (st_reg.addr == OFS_DOW) begin
						st_next.cnt[C_DOW] = host_data_lines_i;
					end else if (st_reg.main_st[MS_PAGE_BIT] && st_reg.addr == OFS_PAGE1) begin
						st_next.rtmode = host_data_lines_i;
					end else if (st_reg.main_st[MS_PAGE_BIT] && st_reg.addr == OFS_PAGE2) begin
						st_next.outmode = host_data_lines_i;
					end else if (st_reg.main_st[MS_PAGE_BIT] && st_reg.addr == OFS_PAGE3) begin
						st_next.ictl0 = host_data_lines_i;
					end else if (st_reg.main_st[MS_PAGE_BIT] && st_reg.addr == OFS_PAGE4) begin
						st_next.ictl1 = host_data_lines_i;
					end else if (st_reg.addr == OFS_PAGE3) begin
						st_next.batt = ~host_data_lines_i[PF_BATT_BIT];
					end else begin
						ram_we = 1'b1;
					end
				end
			end
			default: begin
				st_next.acc = ACC_IDLE;
			end
		endcase
		pf_irq  = st_reg.main_st[MS_PLOSS_BIT];
		any_irq = (st_reg.roll_pend && st_reg.roll_dly == '0) || (pf_irq && !st_reg.outmode[OM_OSC_SEL]);
		if (any_irq) begin
			st_next.main_st[MS_IRQ_BIT] = 1'b1;
		end else begin
			st_next.main_st[MS_IRQ_BIT] = st_reg.main_st[MS_PERIOD_BIT] & st_reg.ictl0[0];
		end
		st_next.irq_n  = 1'b0;
		st_next.irq_oe = (st_next.main_st[MS_IRQ_BIT] & ~st_reg.outmode[OM_OSC_SEL]) | any_irq;
		st_next.mpo = st_reg.outmode[OM_OSC_SEL] ? osc_i : pf_irq;
		// push-pull normally, open drain on backup
		st_next.mpo_oe = backup_supply_i ? ~st_next.mpo : 1'b1;
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			st_reg        <= '0;
			st_reg.acc    <= ACC_IDLE;
			st_reg.irq_n  <= 1'b0;
			st_reg.rtmode <= 8'h00;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops
	assign host_data_lines_o      = st_reg.dout;
	assign host_data_lines_oe_o   = st_reg.doe;
	assign irq_out_n_o            = st_reg.irq_n;
	assign irq_out_n_oe_o         = st_reg.irq_oe;
	assign multi_purpose_out_o    = st_reg.mpo;
	assign multi_purpose_out_oe_o = st_reg.mpo_oe;
endmodule

// [design/rtc_pkg.sv]
// constants, offsets and types shared by the real-time clock host port
package rtc_pkg;
	// bus widths
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	// byte locations (same in both pages unless noted)
	localparam logic [4:0] OFS_MAIN_STATUS  = 5'h00;
	localparam logic [4:0] OFS_PAGE1        = 5'h01; // page 0: time save ctl, page 1: rt mode
	localparam logic [4:0] OFS_PAGE2        = 5'h02; // page 0: unused, page 1: output mode
	localparam logic [4:0] OFS_PAGE3        = 5'h03; // page 0: periodic flags, page 1: irq ctl 0
	localparam logic [4:0] OFS_PAGE4        = 5'h04; // page 0: unused, page 1: irq ctl 1
	localparam logic [4:0] OFS_CNT_FIRST    = 5'h05; // hundredths
	localparam logic [4:0] OFS_CNT_LAST     = 5'h0c; // one past years, which sit at OFS_YEAR; 0x0c is a ram byte
	localparam logic [4:0] OFS_HUND         = 5'h05;
	localparam logic [4:0] OFS_SEC          = 5'h06;
	localparam logic [4:0] OFS_MIN          = 5'h07;
	localparam logic [4:0] OFS_HOUR         = 5'h08;
	localparam logic [4:0] OFS_DOM          = 5'h09;
	localparam logic [4:0] OFS_MON          = 5'h0a;
	localparam logic [4:0] OFS_YEAR         = 5'h0b;
	localparam logic [4:0] OFS_DOW          = 5'h0e;
	localparam logic [4:0] OFS_SCRATCH      = 5'h1e;
	localparam logic [4:0] OFS_TEST         = 5'h1f;
	// counter indices
	localparam int NCNT = 8;
	localparam int C_HUND = 0;
	localparam int C_SEC  = 1;
	localparam int C_MIN  = 2;
	localparam int C_HOUR = 3;
	localparam int C_DOM  = 4;
	localparam int C_MON  = 5;
	localparam int C_YEAR = 6;
	localparam int C_DOW  = 7;
	// field positions
	localparam int MS_IRQ_BIT    = 0; // main status: interrupt pending
	localparam int MS_PLOSS_BIT  = 4; // main status: power fail
	localparam int MS_PERIOD_BIT = 3; // main status: periodic
	localparam int MS_PAGE_BIT   = 6; // main status: register select
	localparam int RTM_12H_BIT   = 2; // rt mode: 12 hour mode when 0
	localparam int RTM_RUN_BIT   = 3; // rt mode: start/stop
	localparam int OM_OSC_SEL    = 7; // output mode: multi output carries oscillator
	localparam int IC1_PF_EN_BIT = 7; // irq ctl 1: power fail enable
	localparam int PF_BATT_BIT   = 6; // periodic flag write: battery backed mode
	localparam int HOUR_PM_BIT   = 7; // hours: half day flag
	// bcd constants
	localparam logic [7:0] BCD_ONE    = 8'h01;
	localparam logic [7:0] BCD_ZERO   = 8'h00;
	localparam logic [7:0] BCD_TWELVE = 8'h12;
	localparam logic [3:0] BCD_NINE   = 4'h9;
	// per counter maximum (bcd) and wrap value
	localparam logic [7:0] CNT_MAX [NCNT] = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h07};
	localparam logic [7:0] CNT_WRAP[NCNT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
	// timing at 100 MHz
	localparam int CLK_MHZ       = 100;
	localparam int LOCK_MIN_US   = 30;
	localparam int LOCK_MAX_US   = 63;
	localparam int ROLL_IRQ_US   = 20;
	localparam int LOCK_CYC      = LOCK_MIN_US * CLK_MHZ; // 3000, inside 30..63 us
	localparam int ROLL_CYC      = ROLL_IRQ_US * CLK_MHZ; // 2000
	localparam int TICK_HZ       = 100;
	localparam int TICK_CYC      = CLK_MHZ * 1000000 / TICK_HZ; // 1,000,000
	localparam int DLY_W         = 12;
	localparam logic [DLY_W-1:0] LOCK_CNT = DLY_W'(LOCK_CYC);
	localparam logic [DLY_W-1:0] ROLL_CNT = DLY_W'(ROLL_CYC);
	// host access state, gray along idle -> read/write -> idle
	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b10
	} rtc_acc_t;
endpackage

// [design/rtc_ram.sv]
// small byte memory holding the page 0 time save ctl, spare, test and scratch locations
`timescale 1ns/10ps
module rtc_ram (
	input  wire logic       mclk_i,  // system clock
	input  wire logic       we_i,    // write strobe
	input  wire logic [4:0] waddr_i, // write location
	input  wire logic [7:0] wdata_i, // write data
	input  wire logic [4:0] raddr_i, // read location
	output logic      [7:0] rdata_o  // registered read data
);
	// storage, no reset: contents start arbitrary
	logic [7:0] mem [32];

	// write port and registered read
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// [verif/rtc_core_assertions.sv]
// pin-level checks on the clock host port
`timescale 1ns/10ps
module rtc_core_assertions (
	input	wire logic	mclk_i,			// system clock
	input	wire logic	rstn_i,			// sync reset, active low
	input	wire logic	cs_n_i,			// chip select
	input	wire logic	rd_n_i,			// read strobe
	input	wire logic	wr_n_i,			// write strobe
	input	wire logic	power_loss_in_n_i,	// power fail pin
	input	wire logic	backup_supply_i,	// battery standby
	input	wire logic	host_data_lines_oe_o,	// data drive
	input	wire logic	irq_out_n_o,		// interrupt level
	input	wire logic	multi_purpose_out_o,	// multi output level
	input	wire logic	multi_purpose_out_oe_o	// multi output drive
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	// power good one edge ahead, then read held through its answer edge
	sequence s_read_held;
		power_loss_in_n_i ##1 (!cs_n_i && !rd_n_i && power_loss_in_n_i) [*3];
	endsequence
	// write held through its two taken edges
	sequence s_write_held;
		(!cs_n_i && !wr_n_i) [*2];
	endsequence
	// chip left deselected
	sequence s_idle_held;
		cs_n_i [*4];
	endsequence
	a_irq_level_low: assert property (irq_out_n_o == 1'b0)
		else $error("interrupt pin level not low");
	a_read_needs_sel: assert property ($rose(host_data_lines_oe_o) |-> !$past(cs_n_i) && !$past(rd_n_i))
		else $error("data driven without select and read");
	a_read_answer_time: assert property (s_read_held |-> host_data_lines_oe_o)
		else $error("read data not driven in time");
	a_read_end_release: assert property (host_data_lines_oe_o && (cs_n_i || rd_n_i)
		|-> ##[1:2] !host_data_lines_oe_o)
		else $error("data still driven after read end");
	a_fail_data_release: assert property (!$past(power_loss_in_n_i) |-> !host_data_lines_oe_o)
		else $error("data driven while power fail low");
	a_write_no_drive: assert property (s_write_held |-> !host_data_lines_oe_o)
		else $error("data driven during write");
	a_idle_no_drive: assert property (s_idle_held |-> !host_data_lines_oe_o)
		else $error("data driven while deselected");
	a_multi_drain: assert property (multi_purpose_out_oe_o && multi_purpose_out_o |-> !$past(backup_supply_i))
		else $error("multi output drives high in standby");
	a_multi_push_pull: assert property ($past(rstn_i) && !$past(backup_supply_i) |-> multi_purpose_out_oe_o)
		else $error("multi output not driven on main supply");
endmodule
bind rtc_core rtc_core_assertions i_chk (.mclk_i, .rstn_i, .cs_n_i, .rd_n_i, .wr_n_i, .power_loss_in_n_i,
	.backup_supply_i, .host_data_lines_oe_o, .irq_out_n_o, .multi_purpose_out_o, .multi_purpose_out_oe_o);

// [verif/rtc_host_model.sv]
// host processor model on the parallel port
`timescale 1ns/10ps
module rtc_host_model (
	input	wire logic		mclk_i,		// system clock
	output	logic			cs_n_o,		// chip select, active low
	output	logic			rd_n_o,		// read strobe, active low
	output	logic			wr_n_o,		// write strobe, active low
	output	logic	[4:0]	addr_o,		// byte location
	output	logic	[7:0]	data_o,		// host data drive
	input	wire logic	[7:0]	data_i,		// resolved data wire
	input	wire logic		data_oe_i	// device drives data
);
	// idle bus at time zero
	initial begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		addr_o = 5'h00;
		data_o = 8'h00;
	end
	task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		addr_o <= a;
		data_o <= d;
		repeat (2) @(posedge mclk_i);
		cs_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		// data held one edge past strobe end, then scrambled
		@(posedge mclk_i);
		data_o <= ~d;
		addr_o <= ~a;
		repeat (2) @(posedge mclk_i);
	endtask
	task automatic bus_read(input logic [4:0] a, output logic [7:0] d, output logic seen);
		int n;
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		addr_o <= a;
		n = 0;
		// hold until the device drives, bounded
		do begin
			@(posedge mclk_i);
			n++;
		end while (data_oe_i !== 1'b1 && n < 8);
		seen = (data_oe_i === 1'b1);
		d = data_i;
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		addr_o <= ~a;
		repeat (3) @(posedge mclk_i);
	endtask
endmodule

// [verif/rtc_host_port_and_counters_test.sv]
// self-checking bench for the clock host port and counters
`timescale 1ns/10ps
// compare, count and report a mismatch
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fail_count++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module rtc_host_port_and_counters_test;
	import rtc_pkg::*;
	logic		mclk_i = 1'b0;			// system clock
	logic		rstn_i = 1'b0;			// sync reset, active low
	logic		power_loss_in_n_i = 1'b1;	// power good
	logic		backup_supply_i = 1'b0;		// main supply
	logic		osc_i = 1'b0;			// oscillator level
	logic		cs_n, rd_n, wr_n;		// host strobes
	logic	[4:0]	addr;				// host location
	logic	[7:0]	host_d, dut_d, bus_d, rd_val;	// data drivers, wire, read
	logic		dut_oe, irq_n, irq_oe, mpo, mpo_oe, seen;	// device pins
	int		fail_count = 0;			// mismatches
	int		total_checks = 0;		// comparisons
	// setup writes: clear test byte, page 1 modes, then page 0
	logic	[4:0]	set_a[9] = '{5'h00, 5'h1f, 5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h00, 5'h02};
	logic	[7:0]	set_d[9] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
	// counter locations and top bcd values
	logic	[4:0]	cnt_a[8] = '{OFS_HUND, OFS_SEC, OFS_MIN, OFS_HOUR, OFS_DOM, OFS_MON, OFS_YEAR, OFS_DOW};
	logic	[7:0]	cnt_d[8] = '{8'h99, 8'h59, 8'h59, 8'h92, 8'h31, 8'h12, 8'h99, 8'h07};
	// battery mode, multi output carries fail irq, fail irq enabled
	logic	[4:0]	pf_a[5] = '{5'h00, 5'h03, 5'h00, 5'h02, 5'h04};
	logic	[7:0]	pf_d[5] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h80};

	assign bus_d = dut_oe ? dut_d : host_d;

	rtc_host_model i_host (.mclk_i, .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr),
		.data_o(host_d), .data_i(bus_d), .data_oe_i(dut_oe));
	rtc_core i_dut (.mclk_i, .rstn_i, .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.location_select_lines_i(addr), .host_data_lines_i(bus_d), .host_data_lines_o(dut_d),
		.host_data_lines_oe_o(dut_oe), .power_loss_in_n_i, .backup_supply_i, .osc_i,
		.irq_out_n_o(irq_n), .irq_out_n_oe_o(irq_oe), .multi_purpose_out_o(mpo),
		.multi_purpose_out_oe_o(mpo_oe));

	// 100 MHz clock
	always #5 mclk_i = ~mclk_i;

	// print counts and verdict, then stop
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// read one byte and compare
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] ex, input string nm);
		i_host.bus_read(a, rd_val, seen);
		`CHK(nm, ex, rd_val)
	endtask

	// cut a hang short, run needs about three and a half thousand cycles
	initial begin
		repeat (20000) @(posedge mclk_i);
		fail_count++;
		report_and_stop();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		foreach (set_a[i]) i_host.bus_write(set_a[i], set_d[i]);
		foreach (cnt_a[i]) i_host.bus_write(cnt_a[i], cnt_d[i]);
		foreach (cnt_a[i]) rd_chk(cnt_a[i], cnt_d[i], "counter byte");
		i_host.bus_write(OFS_SCRATCH, 8'ha5);
		i_host.bus_write(5'h0c, 8'h3c);
		rd_chk(OFS_SCRATCH, 8'ha5, "scratch byte");
		rd_chk(5'h0c, 8'h3c, "spare byte");
		rd_chk(OFS_TEST, 8'h00, "test byte");
		`CHK("irq drive idle", 1'b0, irq_oe)
		// page 0 write to location 2 must leave oscillator routing alone
		for (int i = 0; i < 4; i++) begin
			osc_i <= i[0];
			backup_supply_i <= i[1];
			repeat (4) @(posedge mclk_i);
			`CHK("multi pin", i[0], mpo_oe ? mpo : 1'b1)
			`CHK("multi drive", !(i[0] && i[1]), mpo_oe)
		end
		osc_i <= 1'b0;
		backup_supply_i <= 1'b0;
		foreach (pf_a[i]) i_host.bus_write(pf_a[i], pf_d[i]);
		// write just before the shortest lockout, then one after it
		power_loss_in_n_i <= 1'b0;
		repeat (2900) @(posedge mclk_i);
		i_host.bus_write(OFS_TEST, 8'h33);
		repeat (150) @(posedge mclk_i);
		i_host.bus_write(OFS_SCRATCH, 8'h00);
		i_host.bus_read(OFS_SCRATCH, rd_val, seen);
		`CHK("locked read drive", 1'b0, seen)
		`CHK("irq drive on fail", 1'b1, irq_oe)
		`CHK("multi on fail", 2'b11, {mpo_oe, mpo})
		power_loss_in_n_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		rd_chk(OFS_TEST, 8'h33, "test byte");
		rd_chk(OFS_SCRATCH, 8'ha5, "scratch byte");
		report_and_stop();
	end
endmodule
